// ===== logic/frmca_defines.svh
`ifndef FRMCA_DEFINES_SVH
`define FRMCA_DEFINES_SVH

// ==========================================================================
// Register byte offsets on the Wishbone slave
`define FRMCA_OFF_DATA_LO   8'h00
`define FRMCA_OFF_DATA_HI   8'h04
`define FRMCA_OFF_ADDR_LO   8'h08
`define FRMCA_OFF_ADDR_HI   8'h0C
`define FRMCA_OFF_CTRL      8'h10

// ==========================================================================
// Control register bit positions
`define FRMCA_CTRL_RD       0
`define FRMCA_CTRL_WR       1
`define FRMCA_CTRL_WREN     2
`define FRMCA_CTRL_WRERR    3
`define FRMCA_CTRL_FREE     4
`define FRMCA_CTRL_LATCH_LOAD_ONLY     5
`define FRMCA_CTRL_CONFIG_SPACE_SELECT     6
`define FRMCA_CTRL_TOP      7

// ==========================================================================
// Reset and fixed read values
`define FRMCA_CTRL_TOP_VAL  1'b1
`define FRMCA_ADDR_HI_TOP   1'b1
`define FRMCA_DATA_HI_TOP   2'h0
`define FRMCA_BLANK_WORD    14'h3FFF
`define FRMCA_ZERO_WORD     14'h0000

// ==========================================================================
// Configuration space map, full 16-bit address with the top bit set
`define FRMCA_CFG_UID0      16'h8000
`define FRMCA_CFG_UID1      16'h8001
`define FRMCA_CFG_UID2      16'h8002
`define FRMCA_CFG_UID3      16'h8003
`define FRMCA_CFG_DEVID     16'h8006
`define FRMCA_CFG_CONF1     16'h8007
`define FRMCA_CFG_CONF2     16'h8008

// ==========================================================================
// Timing: self-timed write or erase length in clock cycles
`define FRMCA_WR_BUSY_CYC   16'h0010

`endif

// ===== logic/frmca_pkg.sv
package frmca_pkg;

  // ========================================================================
  // Sequencer states
  typedef enum logic [1:0]
  {
    FRMCA_IDLE,
    FRMCA_RD_WAIT,
    FRMCA_WR_BUSY
  } frmca_state_t;

  // ========================================================================
  // One-cycle command to the flash array or configuration space
  typedef struct packed
  {
    logic        rd;
    logic        load;
    logic        erase;
    logic        prog;
    logic        cfg;
    logic [14:0] addr;
    logic [13:0] wdata;
  } frmca_cmd_t;

  // ========================================================================
  // Whole state of the top module
  typedef struct packed
  {
    frmca_state_t state;
    logic         config_space_select;
    logic         latch_load_only;
    logic         free;
    logic         wrerr;
    logic         wren;
    logic         wr;
    logic         rd;
    logic [7:0]   addr_lo;
    logic [6:0]   addr_hi;
    logic [7:0]   data_lo;
    logic [5:0]   data_hi;
    logic [15:0]  count;
    logic         ack;
    logic [31:0]  dat_o;
    logic         stall;
    frmca_cmd_t   cmd;
  } frmca_top_st_t;

endpackage

// ===== logic/frmca_row_mem.sv
`timescale 1ns/1ps
`include "frmca_defines.svh"

module frmca_row_mem
  import frmca_pkg::*;
#(
  parameter int WORDS_W = 11,
  parameter int ROW_W   = 4
)
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Command and answer
  input  wire frmca_cmd_t  cmd,
  output logic [13:0]      rdata,
  output logic             rvalid
);

  localparam int ROWLEN = 1 << ROW_W;

  typedef struct packed
  {
    logic [ROWLEN-1:0][13:0] latch;
    logic [13:0]             rdata;
    logic                    rvalid;
  } frmca_rm_st_t;

  frmca_rm_st_t               st_reg;
  frmca_rm_st_t               st_next;
  logic [13:0]                mem_array [0:(1<<WORDS_W)-1];
  logic [WORDS_W-1:0]         waddr;
  logic [WORDS_W-ROW_W-1:0]   row;
  logic                       act;

  assign waddr  = cmd.addr[WORDS_W-1:0];
  assign row    = waddr[WORDS_W-1:ROW_W];
  assign act    = ~cmd.cfg;
  assign rdata  = st_reg.rdata;
  assign rvalid = st_reg.rvalid;

  // ========================================================================
  // Latches and read answer
  always_comb
  begin
    st_next        = st_reg;
    st_next.rvalid = cmd.rd & act;
    if (cmd.rd & act)
    begin
      st_next.rdata = mem_array[waddr];
    end
    if (cmd.load & act)
    begin
      st_next.latch[waddr[ROW_W-1:0]] = cmd.wdata;
    end
    if ((cmd.erase | cmd.prog) & act)
    begin
      st_next.latch = {ROWLEN{`FRMCA_BLANK_WORD}};
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      st_reg.latch  <= {ROWLEN{`FRMCA_BLANK_WORD}};
      st_reg.rdata  <= `FRMCA_ZERO_WORD;
      st_reg.rvalid <= 1'b0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // ========================================================================
  // Flash array: not cleared by reset, like real nonvolatile cells
  always_ff @(posedge clk)
  begin
    for (int i = 0; i < ROWLEN; i++)
    begin
      if (cmd.erase & act)
      begin
        mem_array[{row, i[ROW_W-1:0]}] <= `FRMCA_BLANK_WORD;
      end
      else if (cmd.prog & act)
      begin
        mem_array[{row, i[ROW_W-1:0]}] <= st_reg.latch[i];
      end
    end
  end

endmodule

// ===== logic/frmca_cfg_space.sv
`timescale 1ns/1ps
`include "frmca_defines.svh"

module frmca_cfg_space
  import frmca_pkg::*;
#(
  // Arbitrary identity value, not a real part code
  parameter logic [13:0] DEVICE_ID = 14'h0A5A,
  parameter logic [13:0] CONF1     = 14'h3FFF,
  parameter logic [13:0] CONF2     = 14'h3FFF
)
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Command and answer
  input  wire frmca_cmd_t  cmd,
  output logic [13:0]      rdata,
  output logic             rvalid
);

  typedef struct packed
  {
    logic [3:0][13:0] uid;
    logic [13:0]      rdata;
    logic             rvalid;
  } frmca_cs_st_t;

  frmca_cs_st_t st_reg;
  frmca_cs_st_t st_next;
  logic [15:0]  full_addr;

  assign full_addr = {1'b1, cmd.addr};
  assign rdata     = st_reg.rdata;
  assign rvalid    = st_reg.rvalid;

  always_comb
  begin
    st_next        = st_reg;
    st_next.rvalid = cmd.rd & cmd.cfg;
    if (cmd.rd & cmd.cfg)
    begin
      case (full_addr)
        `FRMCA_CFG_UID0, `FRMCA_CFG_UID1, `FRMCA_CFG_UID2, `FRMCA_CFG_UID3:
          st_next.rdata = st_reg.uid[full_addr[1:0]];
        `FRMCA_CFG_DEVID: st_next.rdata = DEVICE_ID;
        `FRMCA_CFG_CONF1: st_next.rdata = CONF1;
        `FRMCA_CFG_CONF2: st_next.rdata = CONF2;
        default:          st_next.rdata = `FRMCA_ZERO_WORD;
      endcase
    end
    if (cmd.prog & cmd.cfg & (full_addr[15:2] == 14'(`FRMCA_CFG_UID0 >> 2)))
    begin
      st_next.uid[full_addr[1:0]] = cmd.wdata;
    end
  end

  // User IDs are nonvolatile and keep their value over reset
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      st_reg.rdata  <= `FRMCA_ZERO_WORD;
      st_reg.rvalid <= 1'b0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

endmodule

// ===== logic/frmca_top.sv
// Behaviour
// - Config select redirects access to ID region.
// - Unlisted config reads return all zeros.
// - User ID words readable and writable.
// - Identity word readable, writes refused.
// - Config words readable, writes refused.
// - Read stalls two slots after next instruction.
// - Low data byte holds word bits 7-0.
// - Latches return blank after write or erase.
// - High data byte bits 13-8, top zero.
// - Config select is control bit 6.
`timescale 1ns/1ps
`include "frmca_defines.svh"

module frmca_top
  import frmca_pkg::*;
#(
  parameter int          WORDS_W       = 11,
  parameter int          ROW_W         = 4,
  parameter logic [15:0] WR_BUSY_CYC   = `FRMCA_WR_BUSY_CYC,
  // Arbitrary identity value, not a real part code
  parameter logic [13:0] DEVICE_ID     = 14'h0A5A,
  parameter logic [13:0] CONF1         = 14'h3FFF,
  parameter logic [13:0] CONF2         = 14'h3FFF
)
(
  // Clock and reset
  input  wire logic        REF_CLK,
  input  wire logic        SYS_RST,
  // Wishbone slave
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [7:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic [31:0]      WB_DAT_O,
  output logic             WB_ACK_O,
  // CPU side
  output logic             FLASH_STALL
);

  frmca_top_st_t st_reg;
  frmca_top_st_t st_next;
  // Store answers
  logic [13:0]   mem_rdata;
  logic          mem_rvalid;
  logic [13:0]   cfg_rdata;
  logic          cfg_rvalid;
  logic [13:0]   rd_word;
  // Bus decode
  logic          bus_req;
  logic          bus_wr;
  logic [31:0]   bus_rdata;
  // Register views
  logic [7:0]    ctrl_rd;
  logic [14:0]   flash_addr;
  logic [13:0]   flash_word_value;
  logic          uid_target;

  assign WB_DAT_O    = st_reg.dat_o;
  assign WB_ACK_O    = st_reg.ack;
  assign FLASH_STALL = st_reg.stall;

  assign flash_addr       = {st_reg.addr_hi, st_reg.addr_lo};
  assign flash_word_value = {st_reg.data_hi, st_reg.data_lo};
  assign uid_target       = ({1'b1, flash_addr} >> 2) == (`FRMCA_CFG_UID0 >> 2);
  // The command word lives one cycle only, so the answering store's
  // own valid flag picks the word when the answer arrives
  assign rd_word          = cfg_rvalid ? cfg_rdata : mem_rdata;

  // ========================================================================
  // Bus view of the control register
  always_comb
  begin
    ctrl_rd                       = 8'h00;
    ctrl_rd[`FRMCA_CTRL_TOP]      = `FRMCA_CTRL_TOP_VAL;
    ctrl_rd[`FRMCA_CTRL_CONFIG_SPACE_SELECT]     = st_reg.config_space_select;
    ctrl_rd[`FRMCA_CTRL_LATCH_LOAD_ONLY]     = st_reg.latch_load_only;
    ctrl_rd[`FRMCA_CTRL_FREE]     = st_reg.free;
    ctrl_rd[`FRMCA_CTRL_WRERR]    = st_reg.wrerr;
    ctrl_rd[`FRMCA_CTRL_WREN]     = st_reg.wren;
    ctrl_rd[`FRMCA_CTRL_WR]       = st_reg.wr;
    ctrl_rd[`FRMCA_CTRL_RD]       = st_reg.rd;
  end

  // ========================================================================
  // Bus read data; unmapped offsets answer zero
  always_comb
  begin
    bus_rdata = 32'h00000000;
    case (WB_ADR_I)
      `FRMCA_OFF_DATA_LO:
      begin
        bus_rdata = {24'h000000, st_reg.data_lo};
      end
      `FRMCA_OFF_DATA_HI:
      begin
        bus_rdata = {24'h000000, `FRMCA_DATA_HI_TOP, st_reg.data_hi};
      end
      `FRMCA_OFF_ADDR_LO:
      begin
        bus_rdata = {24'h000000, st_reg.addr_lo};
      end
      `FRMCA_OFF_ADDR_HI:
      begin
        bus_rdata = {24'h000000, `FRMCA_ADDR_HI_TOP, st_reg.addr_hi};
      end
      `FRMCA_OFF_CTRL:
      begin
        bus_rdata = {24'h000000, ctrl_rd};
      end
      default:
      begin
        bus_rdata = 32'h00000000;
      end
    endcase
  end

  // ========================================================================
  // Next state: bus slave first, sequencer after so its sets win
  always_comb
  begin
    st_next     = st_reg;
    st_next.ack = 1'b0;
    st_next.cmd = '0;
    bus_req     = WB_CYC_I & WB_STB_I & ~st_reg.ack;
    bus_wr      = bus_req & WB_WE_I & WB_SEL_I[0];

    if (bus_req)
    begin
      st_next.ack   = 1'b1;
      st_next.dat_o = bus_rdata;
    end

    if (bus_wr)
    begin
      case (WB_ADR_I)
        `FRMCA_OFF_DATA_LO:
        begin
          st_next.data_lo = WB_DAT_I[7:0];
        end
        `FRMCA_OFF_DATA_HI:
        begin
          st_next.data_hi = WB_DAT_I[5:0];
        end
        `FRMCA_OFF_ADDR_LO:
        begin
          st_next.addr_lo = WB_DAT_I[7:0];
        end
        `FRMCA_OFF_ADDR_HI:
        begin
          st_next.addr_hi = WB_DAT_I[6:0];
        end
        `FRMCA_OFF_CTRL:
        begin
          // Mode bits change even while busy; firmware must wait first
          st_next.config_space_select  = WB_DAT_I[`FRMCA_CTRL_CONFIG_SPACE_SELECT];
          st_next.latch_load_only  = WB_DAT_I[`FRMCA_CTRL_LATCH_LOAD_ONLY];
          st_next.free  = WB_DAT_I[`FRMCA_CTRL_FREE];
          st_next.wrerr = WB_DAT_I[`FRMCA_CTRL_WRERR];
          st_next.wren  = WB_DAT_I[`FRMCA_CTRL_WREN];
          // Start bits can only be set by software
          st_next.wr    = st_reg.wr | WB_DAT_I[`FRMCA_CTRL_WR];
          st_next.rd    = st_reg.rd | WB_DAT_I[`FRMCA_CTRL_RD];
        end
        default:
        begin
        end
      endcase
    end

    // ======================================================================
    // Sequencer: placed after the bus so hardware sets and clears win
    case (st_reg.state)
      FRMCA_IDLE:
      begin
        if (st_reg.rd)
        begin
          st_next.cmd.rd   = 1'b1;
          st_next.cmd.cfg  = st_reg.config_space_select;
          st_next.cmd.addr = flash_addr;
          st_next.stall    = 1'b1;
          st_next.state    = FRMCA_RD_WAIT;
        end
        else if (st_reg.wr & ~st_reg.wren)
        begin
          // Writes without enable are dropped silently
          st_next.wr = 1'b0;
        end
        else if (st_reg.wr & st_reg.config_space_select & ~uid_target)
        begin
          st_next.wrerr = 1'b1;
          st_next.wr    = 1'b0;
        end
        else if (st_reg.wr)
        begin
          st_next.cmd.cfg   = st_reg.config_space_select;
          st_next.cmd.addr  = flash_addr;
          st_next.cmd.wdata = flash_word_value;
          st_next.cmd.load  = ~st_reg.config_space_select & st_reg.latch_load_only;
          st_next.cmd.erase = ~st_reg.config_space_select & ~st_reg.latch_load_only & st_reg.free;
          st_next.cmd.prog  = st_reg.config_space_select | (~st_reg.latch_load_only & ~st_reg.free);
          // The end cycle is counted too, so load one short
          st_next.count     = WR_BUSY_CYC - 16'h0001;
          st_next.stall     = 1'b1;
          st_next.state     = FRMCA_WR_BUSY;
        end
      end

      FRMCA_RD_WAIT:
      begin
        if (mem_rvalid | cfg_rvalid)
        begin
          st_next.data_lo = rd_word[7:0];
          st_next.data_hi = rd_word[13:8];
          st_next.rd      = 1'b0;
          st_next.stall   = 1'b0;
          st_next.state   = FRMCA_IDLE;
        end
      end

      FRMCA_WR_BUSY:
      begin
        if (st_reg.count == 16'h0000)
        begin
          st_next.wr    = 1'b0;
          st_next.free  = 1'b0;
          st_next.stall = 1'b0;
          st_next.state = FRMCA_IDLE;
        end
        else
        begin
          st_next.count = st_reg.count - 16'h0001;
        end
      end

      default:
      begin
        st_next.state = FRMCA_IDLE;
      end
    endcase
  end

  // ========================================================================
  // State register; data bytes keep their value over reset
  // since only reads and bus writes may change them
  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
    begin
      st_reg         <= '0;
      st_reg.data_lo <= st_reg.data_lo;
      st_reg.data_hi <= st_reg.data_hi;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // ========================================================================
  // Storage
  // Program array and its row of write latches
  frmca_row_mem #(
    .WORDS_W (WORDS_W),
    .ROW_W   (ROW_W)
  ) u_row_mem (
    .clk    (REF_CLK),
    .rst    (SYS_RST),
    .cmd    (st_reg.cmd),
    .rdata  (mem_rdata),
    .rvalid (mem_rvalid)
  );

  // User IDs, identity word and configuration words
  frmca_cfg_space #(
    .DEVICE_ID (DEVICE_ID),
    .CONF1     (CONF1),
    .CONF2     (CONF2)
  ) u_cfg_space (
    .clk    (REF_CLK),
    .rst    (SYS_RST),
    .cmd    (st_reg.cmd),
    .rdata  (cfg_rdata),
    .rvalid (cfg_rvalid)
  );

endmodule

// ===== verif/frmca_top_sva.sv
`timescale 1ns/1ps

module frmca_top_sva
(
  // Clock and reset
  input wire logic        REF_CLK,
  input wire logic        SYS_RST,
  // Wishbone slave
  input wire logic        WB_CYC_I,
  input wire logic        WB_STB_I,
  input wire logic        WB_WE_I,
  input wire logic [7:0]  WB_ADR_I,
  input wire logic [3:0]  WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  input wire logic [31:0] WB_DAT_O,
  input wire logic        WB_ACK_O,
  // CPU side
  input wire logic        FLASH_STALL
);
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (SYS_RST);

  logic take;
  logic rd_ack;
  logic rd_go;
  assign take   = WB_CYC_I && WB_STB_I && !WB_ACK_O;
  assign rd_ack = WB_ACK_O && !WB_WE_I;
  // Idle start only, so a busy sequencer cannot mask the timing
  assign rd_go  = take && WB_WE_I && WB_ADR_I == 8'h10 && WB_SEL_I[0] && WB_DAT_I[0]
                  && !WB_DAT_I[1] && !FLASH_STALL;

  // ========================================
  // Bus answer
  AST_ACK_NEXT:
    assert property (take |=> WB_ACK_O) else $error("ack late");
  AST_ACK_ONE:
    assert property (WB_ACK_O |=> !WB_ACK_O) else $error("ack held");
  AST_ACK_CAUSE:
    assert property (WB_ACK_O |-> $past(WB_CYC_I && WB_STB_I)) else $error("ack unasked");
  AST_UPPER_ZERO:
    assert property (rd_ack |-> WB_DAT_O[31:8] == 24'h000000) else $error("upper bits set");
  AST_UNMAPPED:
    assert property (rd_ack && WB_ADR_I > 8'h10 |-> WB_DAT_O == 32'h00000000)
      else $error("unmapped data");
  AST_AHI_TOP:
    assert property (rd_ack && WB_ADR_I == 8'h0C |-> WB_DAT_O[7]) else $error("addr top");

  // ========================================
  // Register layout and read stall
  AST_DHI_TOP:
    assert property (rd_ack && WB_ADR_I == 8'h04 |-> WB_DAT_O[7:6] == 2'h0)
      else $error("data high top");
  AST_CTRL_TOP:
    assert property (rd_ack && WB_ADR_I == 8'h10 |-> WB_DAT_O[7]) else $error("ctrl top");
  AST_RD_STALL:
    assert property (rd_go |=> !FLASH_STALL ##1 FLASH_STALL [*2] ##1 !FLASH_STALL)
      else $error("read stall shape");

  COV_RD: cover property (rd_go);
  COV_UNMAPPED: cover property (rd_ack && WB_ADR_I > 8'h10);
  COV_STALL_END: cover property ($fell(FLASH_STALL));
endmodule

bind frmca_top frmca_top_sva u_sva
(
  .REF_CLK(REF_CLK), .SYS_RST(SYS_RST), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
  .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I),
  .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .FLASH_STALL(FLASH_STALL)
);

// ===== verif/frmca_cpu_model.sv
`timescale 1ns/1ps

module frmca_cpu_model
(
  // Clock
  input  wire logic        clk,
  // Wishbone master
  output logic             cyc,
  output logic             stb,
  output logic             we,
  output logic [7:0]       adr,
  output logic [3:0]       sel,
  output logic [31:0]      dat,
  input  wire logic [31:0] dat_o,
  input  wire logic        ack
);
  initial
  begin
    cyc = 1'b0;
    stb = 1'b0;
    we  = 1'b0;
    adr = 8'h00;
    sel = 4'hF;
    dat = 32'h00000000;
  end

  // ========================================
  // Bus cycles
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                      output logic [7:0] q);
    int n;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= {24'h000000, d};
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (ack !== 1'b1 && n < 20);
    if (ack !== 1'b1)
    begin
      testbench.error_cnt++;
      testbench.test_done();
    end
    q = dat_o[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    // Released lines must not keep looking valid
    adr <= ~a;
    dat <= ~dat;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    xfer(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    xfer(1'b0, a, 8'h00, q);
  endtask

  // ========================================
  // Firmware routines
  task automatic fw_cmd(input logic [7:0] c);
    logic [7:0] q;
    int n;
    wr(8'h10, c);
    n = 0;
    do
    begin
      rd(8'h10, q);
      n++;
    end
    while (q[1:0] !== 2'h0 && n < 40);
    if (q[1:0] !== 2'h0)
    begin
      testbench.error_cnt++;
      testbench.test_done();
    end
  endtask

  task automatic fw_read(input logic [7:0] lo, input logic cfg, output logic [13:0] w);
    logic [7:0] l;
    logic [7:0] h;
    wr(8'h08, lo);
    wr(8'h0C, 8'h00);
    wr(8'h10, {1'b0, cfg, 6'h00});
    fw_cmd({1'b0, cfg, 6'h01});
    rd(8'h00, l);
    rd(8'h04, h);
    w = {h[5:0], l};
  endtask

  task automatic fw_write(input logic [7:0] lo, input logic [13:0] w, input logic [7:0] c);
    wr(8'h08, lo);
    wr(8'h0C, 8'h00);
    wr(8'h00, w[7:0]);
    wr(8'h04, {2'h0, w[13:8]});
    fw_cmd(c);
  endtask
endmodule

// ===== verif/testbench.sv
`timescale 1ns/1ps

module testbench;
  // Arbitrary identity and option values
  localparam logic [13:0] ID_V = 14'h1357;
  localparam logic [13:0] CF1  = 14'h2A1C;
  localparam logic [13:0] CF2  = 14'h15E3;

  logic        ref_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        cyc;
  logic        stb;
  logic        we;
  logic        ack;
  logic        stall;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] dat_i;
  logic [31:0] dat_o;
  logic [7:0]  q;
  logic [13:0] w;
  logic [13:0] e;
  int          error_cnt = 0;
  int          checked = 0;

  always #2.5 ref_clk = ~ref_clk;

  frmca_cpu_model cpu
  (
    .clk(ref_clk), .cyc(cyc), .stb(stb), .we(we), .adr(adr), .sel(sel),
    .dat(dat_i), .dat_o(dat_o), .ack(ack)
  );

  frmca_top #(.WR_BUSY_CYC(16'h0004), .DEVICE_ID(ID_V), .CONF1(CF1), .CONF2(CF2)) DUT
  (
    .REF_CLK(ref_clk), .SYS_RST(sys_rst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat_i), .WB_DAT_O(dat_o), .WB_ACK_O(ack),
    .FLASH_STALL(stall)
  );

  // ========================================
  // Checking and closing
  task automatic chk(input string nm, input logic [13:0] seen, input logic [13:0] exp);
    checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic test_done();
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // ========================================
  // Sequence
  initial
  begin
    repeat (10) @(posedge ref_clk);
    sys_rst <= 1'b0;
    cpu.rd(8'h10, q); chk("ctrl", {6'h00, q}, 14'h0080);
    cpu.rd(8'h0C, q); chk("addr_hi", {6'h00, q}, 14'h0080);
    cpu.rd(8'h08, q); chk("addr_lo", {6'h00, q}, 14'h0000);
    cpu.wr(8'h14, 8'h5A);
    cpu.rd(8'h14, q); chk("unmapped", {6'h00, q}, 14'h0000);
    cpu.wr(8'h04, 8'hFF);
    cpu.rd(8'h04, q); chk("data_hi", {6'h00, q}, 14'h003F);
    cpu.wr(8'h00, 8'hA5);
    cpu.rd(8'h00, q); chk("data_lo", {6'h00, q}, 14'h00A5);
    // User IDs written, then refused writes to fixed words
    for (int i = 0; i < 4; i++)
      cpu.fw_write(8'(i), 14'h1100 + 14'(i), 8'h46);
    for (int i = 6; i < 9; i++)
    begin
      cpu.fw_write(8'(i), 14'h0F0F, 8'h46);
      cpu.rd(8'h10, q); chk("wr_error", {6'h00, q}, 14'h00CC);
      cpu.wr(8'h10, 8'h44);
    end
    // Whole configuration window, unlisted places read zero
    for (int i = 0; i < 10; i++)
    begin
      e = (i < 4) ? 14'h1100 + 14'(i) : (i == 6) ? ID_V : (i == 7) ? CF1 :
          (i == 8) ? CF2 : 14'h0000;
      cpu.fw_read(8'(i), 1'b1, w); chk("cfg_word", w, e);
    end
    // Row erase, one latch loaded, program, verify
    cpu.fw_write(8'h20, 14'h0000, 8'h16);
    cpu.fw_write(8'h21, 14'h1234, 8'h26);
    cpu.fw_cmd(8'h06);
    cpu.fw_read(8'h20, 1'b0, w); chk("row_blank", w, 14'h3FFF);
    cpu.fw_read(8'h21, 1'b0, w); chk("row_word", w, 14'h1234);
    cpu.rd(8'h10, q); chk("rd_clear", {6'h00, q}, 14'h0080);
    chk("stall_idle", {13'h0000, stall}, 14'h0000);
    // Latches must be blank again after the first program
    cpu.fw_cmd(8'h06);
    cpu.fw_read(8'h21, 1'b0, w); chk("latch_reset", w, 14'h3FFF);
    test_done();
  end
endmodule
